// ### dv/dma_channel_config_control_chk.sv
// Purpose: port-level checks of the dma channel configuration block
// Assumes: single clock domain, channel index 0 watched in detail
// Notes: config bits are shadowed from software writes to channel one
`timescale 1ns/100ps
module dma_channel_config_control_chk
    import dma_cfg_pkg::*;
(
    input wire logic clk_i, // system clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic [31:0] addr_i, // register address
    input wire logic [31:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    input wire logic [31:0] rdata_o, // read data
    input wire logic irq_o, // level interrupt
    input wire logic channel_one_completion_irq_o, // channel one completion
    input wire logic [NUM_CH-1:0] tc_o, // terminal count pulses
    input wire logic [NUM_CH-1:0] flush_o, // flush pulses
    input wire logic [NUM_CH-1:0] busy_o, // channel active
    input wire logic [NUM_CH-1:0] link_style_select_o, // link style
    input wire logic [NUM_CH-1:0][31:0] descriptor_start_pointer_o // descriptor addresses
);
    logic tc_en;
    logic flush_en;
    logic cfg_wr;
    logic ctrl_wr;
    assign cfg_wr = wr_i && addr_i == CH_CFG_ADDR[0];
    assign ctrl_wr = wr_i && addr_i == CH_CTRL_ADDR;
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tc_en <= 1'b0;
            flush_en <= 1'b0;
        end
        else if (cfg_wr)
        begin
            tc_en <= wdata_i[TC_ENABLE_BIT];
            flush_en <= wdata_i[FLUSH_ON_STOP_BIT];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_rdata_quiet: assert property (!rd_i |=> rdata_o == 32'h00000000)
        else $error("read data not zero outside the read answer cycle");
    a_tc_masked: assert property (tc_o[0] |-> tc_en)
        else $error("terminal count pulse while its enable is clear");
    a_tc_pulse: assert property (tc_o[0] |=> !tc_o[0])
        else $error("terminal count pulse longer than one cycle");
    a_flush_masked: assert property (flush_o[0] |-> flush_en && busy_o[0])
        else $error("buffer write-out while flush bit is clear");
    a_stop_idle: assert property (ctrl_wr && wdata_i[CTRL_STOP_LSB] && busy_o[0] && !flush_en |=> !busy_o[0])
        else $error("channel still busy after stop without flush");
    a_start_busy: assert property (ctrl_wr && wdata_i[CTRL_START_LSB] && !wdata_i[CTRL_STOP_LSB] && !busy_o[0]
        |=> busy_o[0])
        else $error("channel not busy after start");
    a_done_irq_cause: assert property ($rose(channel_one_completion_irq_o) |-> $past(busy_o[0]))
        else $error("completion interrupt without an active transaction");
    a_done_irq_hold: assert property (channel_one_completion_irq_o
        && !(wr_i && addr_i == IRQ_STATUS_ADDR && wdata_i[IRQ_DONE_LSB]) |=> channel_one_completion_irq_o)
        else $error("completion interrupt dropped without clear");
    a_style_follow: assert property (cfg_wr |=> link_style_select_o[0] == $past(wdata_i[LINK_STYLE_BIT]))
        else $error("link style output does not follow config write");
    a_desc_ptr_load: assert property (wr_i && addr_i == DESC_PTR_ADDR[0]
        |=> descriptor_start_pointer_o[0] == $past(wdata_i))
        else $error("descriptor pointer not loaded");
    cover property (tc_o[0]);
    cover property ($fell(busy_o[0]));
    cover property (irq_o);
    cover property (link_style_select_o[0] && busy_o[0]);
endmodule

bind dma_channel_config_control dma_channel_config_control_chk chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .channel_one_completion_irq_o(channel_one_completion_irq_o), .tc_o(tc_o), .flush_o(flush_o),
    .busy_o(busy_o), .link_style_select_o(link_style_select_o),
    .descriptor_start_pointer_o(descriptor_start_pointer_o));

// ### dv/dma_channel_config_control_tb_top.sv
// Purpose: self-checking bench of the dma channel configuration block
// Assumes: register port with read data one cycle after the strobe
// Notes: channel two runs single, channel one continuous and link style
`timescale 1ns/100ps
module dma_channel_config_control_tb_top
    import dma_cfg_pkg::*;
;
    logic clk_i;
    logic rst_n_i;
    logic [31:0] addr_i;
    logic [31:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [NUM_CH-1:0] descriptor_link_valid_i;
    logic [31:0] rdata_o;
    logic irq_o;
    logic ch1_irq;
    logic ch2_irq;
    logic [NUM_CH-1:0] tc_o;
    logic [NUM_CH-1:0] flush_o;
    logic [NUM_CH-1:0] busy_o;
    logic [NUM_CH-1:0] link_style_select_o;
    logic [NUM_CH-1:0][31:0] descriptor_start_pointer_o;
    logic [NUM_CH-1:0][31:0] src_addr_o;
    logic [NUM_CH-1:0][31:0] dst_addr_o;
    logic [31:0] d;
    int fails;
    int tests_run;
    int tc_cnt [NUM_CH];
    int flush_cnt;

    dma_channel_config_control dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .descriptor_link_valid_i(descriptor_link_valid_i), .rdata_o(rdata_o),
        .irq_o(irq_o), .channel_one_completion_irq_o(ch1_irq), .channel_two_completion_irq_o(ch2_irq),
        .tc_o(tc_o), .flush_o(flush_o), .busy_o(busy_o), .link_style_select_o(link_style_select_o),
        .descriptor_start_pointer_o(descriptor_start_pointer_o), .src_addr_o(src_addr_o),
        .dst_addr_o(dst_addr_o));

    always #5 clk_i = ~clk_i;

    always @(posedge clk_i)
    begin
        if (tc_o[0] === 1'b1) tc_cnt[0]++;
        if (tc_o[1] === 1'b1) tc_cnt[1]++;
        if (flush_o !== 2'h0) flush_cnt++;
    end

    task automatic print_verdict;
        if (fails == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        // let the write settle before the caller looks at outputs
        #1;
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        v = rdata_o;
    endtask

    // alternate set word address: base + 4 * {channel, set, word}
    function automatic logic [31:0] alt(input int c, input int s, input logic [1:0] w);
        return ALT_SET_BASE + 32'(c * 32 + s * 16) + {28'h0000000, w, 2'b00};
    endfunction

    task automatic set_prog(input int c, input int s, input logic [31:0] src, input logic [31:0] cnt);
        wr(alt(c, s, WORD_SRC), src);
        wr(alt(c, s, WORD_DST), src + 32'h20000000);
        wr(alt(c, s, WORD_CNT), cnt);
    endtask

    // mode 0 waits for idle, mode 1 for the source address top byte
    task automatic wait_for(input int c, input int mode, input logic [7:0] hi);
        for (int i = 0; i < 300; i++)
        begin
            @(posedge clk_i);
            #1;
            if (mode == 0 ? busy_o[c] === 1'b0 : src_addr_o[c][31:24] === hi)
                return;
        end
        chk("wait", 32'h1, 32'h0);
        print_verdict();
    endtask

    task automatic t_reset_regs;
        rd(CFG_ONE_ADDR, d);
        chk("cfg_one", CFG_RESET, d);
        rd(CFG_TWO_ADDR, d);
        chk("cfg_two", CFG_RESET, d);
        rd(IRQ_MASK_ADDR, d);
        chk("irq_mask", 32'h00000000, d);
        rd(32'h400a2ffc, d);
        chk("unmapped", 32'h00000000, d);
    endtask

    task automatic t_prio_ptr;
        wr(GLOBAL_PRIO_ADDR, 32'h00000001);
        rd(GLOBAL_PRIO_ADDR, d);
        chk("prio", 32'h00000001, d);
        wr(DESC_PTR_ADDR[0], 32'h20011000);
        chk("desc_ptr", 32'h20011000, descriptor_start_pointer_o[0]);
    endtask

    task automatic t_single;
        set_prog(1, 0, 32'h33000000, 32'h00000080);
        set_prog(1, 1, 32'h11000000, 32'h00000080);
        wr(CFG_TWO_ADDR, 32'h10000000);
        wr(IRQ_MASK_ADDR, 32'h00000002);
        wr(CH_CTRL_ADDR, 32'h00000002);
        wait_for(1, 1, 8'h11);
        // destination word lands two cycles after the source word
        repeat (2) @(posedge clk_i);
        #1;
        chk("dst_set", 32'h31, {24'h0, dst_addr_o[1][31:24]});
        wait_for(1, 0, 8'h00);
        repeat (20) @(posedge clk_i);
        #1;
        chk("single_busy", 32'h0, {31'h0, busy_o[1]});
        chk("tc_masked", 32'h0, tc_cnt[1]);
        chk("ch2_irq", 32'h1, {31'h0, ch2_irq});
        chk("irq", 32'h1, {31'h0, irq_o});
        rd(CFG_TWO_ADDR, d);
        chk("no_toggle", 32'h10000000, d);
        wr(IRQ_MASK_ADDR, 32'h00000000);
        @(posedge clk_i);
        #1;
        chk("irq_masked", 32'h0, {31'h0, irq_o});
        wr(IRQ_STATUS_ADDR, 32'h00000002);
        @(posedge clk_i);
        #1;
        chk("ch2_clear", 32'h0, {31'h0, ch2_irq});
    endtask

    task automatic t_continuous;
        set_prog(0, 0, 32'h44000000, 32'h00000008);
        set_prog(0, 1, 32'h55000000, 32'h00000008);
        wr(CFG_ONE_ADDR, 32'h62000000);
        wr(CH_CTRL_ADDR, 32'h00000001);
        wait_for(0, 1, 8'h44);
        wait_for(0, 1, 8'h55);
        chk("cont_busy", 32'h1, {31'h0, busy_o[0]});
        chk("tc_seen", 32'h1, {31'h0, tc_cnt[0] > 0});
        wr(CH_CTRL_ADDR, 32'h00000100);
        @(posedge clk_i);
        #1;
        chk("stop_busy", 32'h0, {31'h0, busy_o[0]});
        chk("no_flush", 32'h0, flush_cnt);
        chk("ch1_irq", 32'h1, {31'h0, ch1_irq});
        wr(IRQ_STATUS_ADDR, 32'h0000000f);
    endtask

    task automatic t_link;
        wr(CFG_ONE_ADDR, 32'h80000000);
        chk("style", 32'h1, {31'h0, link_style_select_o[0]});
        wr(CH_CTRL_ADDR, 32'h00000001);
        wait_for(0, 0, 8'h00);
        rd(IRQ_STATUS_ADDR, d);
        chk("link_end", 32'h1, {31'h0, d[IRQ_LINK_END_LSB]});
        // chained descriptors keep the channel busy; a stop with flush set writes out
        @(posedge clk_i);
        descriptor_link_valid_i <= 2'h1;
        wr(CFG_ONE_ADDR, 32'h88000000);
        wr(CH_CTRL_ADDR, 32'h00000001);
        repeat (30) @(posedge clk_i);
        #1;
        chk("link_chain", 32'h1, {31'h0, busy_o[0]});
        wr(CH_CTRL_ADDR, 32'h00000100);
        @(posedge clk_i);
        #1;
        chk("flush_seen", 32'h1, flush_cnt);
        chk("flush_idle", 32'h0, {31'h0, busy_o[0]});
    endtask

    initial
    begin
        clk_i = 1'b0;
        rst_n_i = 1'b0;
        addr_i = 32'h00000000;
        wdata_i = 32'h00000000;
        wr_i = 1'b0;
        rd_i = 1'b0;
        descriptor_link_valid_i = 2'h0;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset_regs();
        t_prio_ptr();
        t_single();
        t_continuous();
        t_link();
        print_verdict();
    end
endmodule

// ### include/dma_cfg_pkg.sv
// Purpose: shared constants and types of the dma channel configuration block
// Assumes: 32-bit register port, byte addresses, two channels
// Notes: alternate register sets live in a small memory indexed {channel, set, word}
package dma_cfg_pkg;

    localparam int NUM_CH = 2;
    localparam int CH_IDX_W = 1;
    localparam int IRQ_W = 2 * NUM_CH;
    localparam int MEM_ADDR_W = CH_IDX_W + 3;
    localparam int DATA_W = 32;

    // register byte addresses
    localparam logic [31:0] CFG_ONE_ADDR = 32'h400a286c;
    localparam logic [31:0] CFG_TWO_ADDR = 32'h400a28ac;
    localparam logic [NUM_CH-1:0][31:0] CH_CFG_ADDR = {CFG_TWO_ADDR, CFG_ONE_ADDR};
    localparam logic [31:0] GLOBAL_PRIO_ADDR = 32'h400a2300;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'h400a2310;
    localparam logic [31:0] IRQ_MASK_ADDR = 32'h400a2314;
    localparam logic [31:0] CH_STATUS_ADDR = 32'h400a2318;
    localparam logic [31:0] CH_CTRL_ADDR = 32'h400a231c;
    localparam logic [NUM_CH-1:0][31:0] DESC_PTR_ADDR = {32'h400a2324, 32'h400a2320};
    // alternate sets: base + 4 * {channel, set, word}; word 0 source, 1 destination, 2 byte count
    localparam logic [31:0] ALT_SET_BASE = 32'h400a2400;
    localparam logic [31:0] ALT_SET_SPAN = 32'h00000040;

    // channel configuration fields
    localparam int LINK_STYLE_BIT = 31;
    localparam int CONT_EXEC_BIT = 30;
    localparam int AUTO_TOGGLE_BIT = 29;
    localparam int SET_SELECT_BIT = 28;
    localparam int FLUSH_ON_STOP_BIT = 27;
    localparam int LINK_END_MASK_BIT = 26;
    localparam int TC_ENABLE_BIT = 25;
    localparam int COMPLETION_MASK_BIT = 24;

    // global priority, control and interrupt fields
    localparam int PRIO_RR_BIT = 0;
    localparam int CTRL_START_LSB = 0;
    localparam int CTRL_STOP_LSB = 8;
    localparam int IRQ_DONE_LSB = 0;
    localparam int IRQ_LINK_END_LSB = NUM_CH;

    localparam logic [1:0] WORD_SRC = 2'h0;
    localparam logic [1:0] WORD_DST = 2'h1;
    localparam logic [1:0] WORD_CNT = 2'h2;

    localparam logic [31:0] CFG_RESET = 32'h00000000;
    localparam logic [31:0] DESC_PTR_RESET = 32'h00000000;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = '0;

    typedef enum logic [1:0] {
        CH_IDLE,
        CH_FETCH,
        CH_RUN,
        CH_FLUSH
    } ch_state_t;

    typedef struct packed {
        ch_state_t st;
        logic [1:0] word;
        logic pend;
        logic busy;
        logic tc;
        logic flush;
        logic done_irq;
        logic [31:0] cfg;
        logic [31:0] desc_ptr;
        logic [31:0] src;
        logic [31:0] dst;
        logic [31:0] cnt;
    } chan_t;

    typedef struct packed {
        chan_t [NUM_CH-1:0] ch;
        logic rr_mode;
        logic [CH_IDX_W-1:0] rr_last;
        logic [IRQ_W-1:0] status;
        logic [IRQ_W-1:0] mask;
        logic [31:0] rd_data;
        logic irq;
    } top_state_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage

// ### verilog/alt_set_mem.sv
// Purpose: storage for the alternate register sets of all channels
// Assumes: one write port from software, one read port for the channels
// Notes: read data come out of a register one cycle after the read enable
`timescale 1ns/100ps
module alt_set_mem
    import dma_cfg_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int ADDR_W = 4
)
(
    input wire logic clk_i,               // system clock
    input wire logic rst_n_i,             // async reset, active low
    input wire logic we_i,                // write enable
    input wire logic [ADDR_W-1:0] waddr_i, // write index
    input wire logic [WIDTH-1:0] wdata_i, // write data
    input wire logic re_i,                // read enable
    input wire logic [ADDR_W-1:0] raddr_i, // read index
    output logic [WIDTH-1:0] rdata_o      // registered read data
);

    logic [WIDTH-1:0] mem [2**ADDR_W];

    always_ff @(posedge clk_i)
    begin
        if (we_i)
        begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rdata_o <= '0;
        end
        else if (re_i)
        begin
            rdata_o <= mem[raddr_i];
        end
    end

endmodule

// ### verilog/dma_channel_config_control.sv
// Purpose: per-channel configuration and sequencing of a two-channel dma controller
// Assumes: inputs synchronous to clk_i; software port with read data one cycle later
// Notes: a transaction moves the loaded byte count in beats of BEAT_BYTES per cycle
`timescale 1ns/100ps

// Notes on behaviour
// - continuous bit set, link style clear: after a transaction, reload from the selected alternate set and go on.
// - auto-toggle bit set: invert the set select at each finished transaction.
// - set select 0 fetches alternate set zero, 1 fetches set one.
// - flush bit clear: a stop ends the transfer and discards buffered data.
// - terminal-count enable clear: the terminal-count output stays low.
// - completion mask clear: a finished transaction raises the completion interrupt.
// - global priority value 1 selects round-robin arbitration, otherwise fixed priority.
// - continuous bit clear, link style clear: one transaction, then stop with no reload.
// - each alternate set holds source address, destination address and byte count.
module dma_channel_config_control
    import dma_cfg_pkg::*;
#(
    parameter int BEAT_BYTES = 4
)
(
    input wire logic clk_i,                                    // system clock, 100 MHz
    input wire logic rst_n_i,                                  // async reset, active low
    input wire logic [31:0] addr_i,                            // register byte address
    input wire logic [31:0] wdata_i,                           // register write data
    input wire logic wr_i,                                     // write strobe
    input wire logic rd_i,                                     // read strobe
    input wire logic [NUM_CH-1:0] descriptor_link_valid_i,     // link valid of the descriptor just ended
    output logic [31:0] rdata_o,                               // read data, cycle after rd_i
    output logic irq_o,                                        // level interrupt
    output logic channel_one_completion_irq_o,                 // channel one completion interrupt
    output logic channel_two_completion_irq_o,                 // channel two completion interrupt
    output logic [NUM_CH-1:0] tc_o,                            // terminal-count pulse per channel
    output logic [NUM_CH-1:0] flush_o,                         // buffer write-out pulse on stop
    output logic [NUM_CH-1:0] busy_o,                          // channel active
    output logic [NUM_CH-1:0] link_style_select_o,             // channel in descriptor-link style
    output logic [NUM_CH-1:0][31:0] descriptor_start_pointer_o, // descriptor address per channel
    output logic [NUM_CH-1:0][31:0] src_addr_o,                // current source address
    output logic [NUM_CH-1:0][31:0] dst_addr_o                 // current destination address
);

    localparam logic [31:0] BEAT = 32'(BEAT_BYTES);

    top_state_t st;
    top_state_t next_st;
    reg_req_t req;
    logic mem_we;
    logic [MEM_ADDR_W-1:0] mem_waddr;
    logic mem_re;
    logic [MEM_ADDR_W-1:0] mem_raddr;
    logic [31:0] mem_rdata;
    logic [IRQ_W-1:0] w1c;
    logic [IRQ_W-1:0] events;
    logic gnt_found;
    logic [CH_IDX_W-1:0] gnt;
    logic [CH_IDX_W-1:0] cand;
    logic start;
    logic stop;
    logic done;
    logic [31:0] alt_off;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign alt_off = req.addr - ALT_SET_BASE;

    // software writes into the alternate sets
    always_comb
    begin
        mem_we = req.wr && (req.addr >= ALT_SET_BASE) && (alt_off < ALT_SET_SPAN);
        mem_waddr = alt_off[MEM_ADDR_W+1:2];
    end

    alt_set_mem #(
        .WIDTH(DATA_W),
        .ADDR_W(MEM_ADDR_W)
    ) u_alt_set_mem (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .we_i(mem_we),
        .waddr_i(mem_waddr),
        .wdata_i(req.wdata),
        .re_i(mem_re),
        .raddr_i(mem_raddr),
        .rdata_o(mem_rdata)
    );

    always_comb
    begin
        next_st = st;
        mem_re = 1'b0;
        mem_raddr = '0;
        events = '0;
        gnt_found = 1'b0;
        gnt = '0;
        cand = '0;
        start = 1'b0;
        stop = 1'b0;
        done = 1'b0;

        // register writes
        for (int c = 0; c < NUM_CH; c++)
        begin
            if (req.wr && req.addr == CH_CFG_ADDR[c])
            begin
                next_st.ch[c].cfg = req.wdata;
            end
            if (req.wr && req.addr == DESC_PTR_ADDR[c])
            begin
                next_st.ch[c].desc_ptr = req.wdata;
            end
        end
        if (req.wr && req.addr == GLOBAL_PRIO_ADDR)
        begin
            next_st.rr_mode = req.wdata[PRIO_RR_BIT];
        end
        if (req.wr && req.addr == IRQ_MASK_ADDR)
        begin
            next_st.mask = req.wdata[IRQ_W-1:0];
        end
        w1c = (req.wr && req.addr == IRQ_STATUS_ADDR) ? req.wdata[IRQ_W-1:0] : '0;

        // one channel at a time may fetch from the alternate sets
        for (int k = 0; k < NUM_CH; k++)
        begin
            if (st.rr_mode)
            begin
                cand = CH_IDX_W'((int'(st.rr_last) + 1 + k) % NUM_CH);
            end
            else
            begin
                cand = CH_IDX_W'(k);
            end
            if (!gnt_found && st.ch[cand].st == CH_FETCH && !st.ch[cand].pend)
            begin
                gnt_found = 1'b1;
                gnt = cand;
            end
        end
        if (gnt_found)
        begin
            next_st.rr_last = gnt;
        end

        for (int c = 0; c < NUM_CH; c++)
        begin
            next_st.ch[c].tc = 1'b0;
            next_st.ch[c].flush = 1'b0;
            start = req.wr && req.addr == CH_CTRL_ADDR && req.wdata[CTRL_START_LSB + c];
            stop = req.wr && req.addr == CH_CTRL_ADDR && req.wdata[CTRL_STOP_LSB + c];
            done = 1'b0;
            unique case (st.ch[c].st)
                CH_IDLE:
                begin
                    if (start)
                    begin
                        next_st.ch[c].st = CH_FETCH;
                        next_st.ch[c].word = WORD_SRC;
                        next_st.ch[c].pend = 1'b0;
                    end
                end
                CH_FETCH:
                begin
                    if (st.ch[c].pend)
                    begin
                        next_st.ch[c].pend = 1'b0;
                        next_st.ch[c].word = st.ch[c].word + 2'h1;
                        unique case (st.ch[c].word)
                            WORD_SRC:
                            begin
                                next_st.ch[c].src = mem_rdata;
                            end
                            WORD_DST:
                            begin
                                next_st.ch[c].dst = mem_rdata;
                            end
                            default:
                            begin
                                next_st.ch[c].cnt = mem_rdata;
                                next_st.ch[c].st = CH_RUN;
                            end
                        endcase
                    end
                    else if (gnt_found && gnt == CH_IDX_W'(c))
                    begin
                        mem_re = 1'b1;
                        mem_raddr = {CH_IDX_W'(c), st.ch[c].cfg[SET_SELECT_BIT], st.ch[c].word};
                        next_st.ch[c].pend = 1'b1;
                    end
                end
                CH_RUN:
                begin
                    if (st.ch[c].cnt <= BEAT)
                    begin
                        next_st.ch[c].cnt = '0;
                        done = 1'b1;
                    end
                    else
                    begin
                        next_st.ch[c].cnt = st.ch[c].cnt - BEAT;
                        next_st.ch[c].src = st.ch[c].src + BEAT;
                        next_st.ch[c].dst = st.ch[c].dst + BEAT;
                    end
                end
                CH_FLUSH:
                begin
                    next_st.ch[c].st = CH_IDLE;
                end
            endcase

            if (done)
            begin
                if (st.ch[c].cfg[AUTO_TOGGLE_BIT])
                begin
                    next_st.ch[c].cfg[SET_SELECT_BIT] = ~next_st.ch[c].cfg[SET_SELECT_BIT];
                end
                if (!st.ch[c].cfg[COMPLETION_MASK_BIT])
                begin
                    events[IRQ_DONE_LSB + c] = 1'b1;
                end
                next_st.ch[c].tc = st.ch[c].cfg[TC_ENABLE_BIT];
                next_st.ch[c].word = WORD_SRC;
                next_st.ch[c].pend = 1'b0;
                if (st.ch[c].cfg[LINK_STYLE_BIT])
                begin
                    // descriptor-link style: follow the chain while link valid is set
                    if (descriptor_link_valid_i[c])
                    begin
                        next_st.ch[c].st = CH_FETCH;
                    end
                    else
                    begin
                        next_st.ch[c].st = CH_IDLE;
                        if (!st.ch[c].cfg[LINK_END_MASK_BIT])
                        begin
                            events[IRQ_LINK_END_LSB + c] = 1'b1;
                        end
                    end
                end
                else if (st.ch[c].cfg[CONT_EXEC_BIT])
                begin
                    next_st.ch[c].st = CH_FETCH;
                end
                else
                begin
                    next_st.ch[c].st = CH_IDLE;
                end
            end

            if (stop && st.ch[c].st != CH_IDLE)
            begin
                next_st.ch[c].pend = 1'b0;
                if (st.ch[c].cfg[FLUSH_ON_STOP_BIT])
                begin
                    next_st.ch[c].st = CH_FLUSH;
                    next_st.ch[c].flush = 1'b1;
                end
                else
                begin
                    next_st.ch[c].st = CH_IDLE;
                end
            end
            next_st.ch[c].busy = next_st.ch[c].st != CH_IDLE;
        end

        // a new event wins over a clear in the same cycle
        next_st.status = (st.status & ~w1c) | events;
        next_st.irq = |(next_st.status & next_st.mask);
        for (int c = 0; c < NUM_CH; c++)
        begin
            next_st.ch[c].done_irq = next_st.status[IRQ_DONE_LSB + c];
        end

        // read data stand for one cycle only
        next_st.rd_data = '0;
        if (req.rd)
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                if (req.addr == CH_CFG_ADDR[c])
                begin
                    next_st.rd_data = st.ch[c].cfg;
                end
                if (req.addr == DESC_PTR_ADDR[c])
                begin
                    next_st.rd_data = st.ch[c].desc_ptr;
                end
                if (req.addr == CH_STATUS_ADDR)
                begin
                    next_st.rd_data[c] = st.ch[c].busy;
                end
            end
            if (req.addr == GLOBAL_PRIO_ADDR)
            begin
                next_st.rd_data[PRIO_RR_BIT] = st.rr_mode;
            end
            if (req.addr == IRQ_STATUS_ADDR)
            begin
                next_st.rd_data[IRQ_W-1:0] = st.status;
            end
            if (req.addr == IRQ_MASK_ADDR)
            begin
                next_st.rd_data[IRQ_W-1:0] = st.mask;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int c = 0; c < NUM_CH; c++)
            begin
                st.ch[c] <= '{st: CH_IDLE, word: WORD_SRC, pend: 1'b0, busy: 1'b0, tc: 1'b0, flush: 1'b0,
                              done_irq: 1'b0, cfg: CFG_RESET, desc_ptr: DESC_PTR_RESET,
                              src: 32'h00000000, dst: 32'h00000000, cnt: 32'h00000000};
            end
            st.rr_mode <= 1'b0;
            st.rr_last <= '0;
            st.status <= '0;
            st.mask <= IRQ_MASK_RESET;
            st.rd_data <= 32'h00000000;
            st.irq <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rd_data;
    assign irq_o = st.irq;
    assign channel_one_completion_irq_o = st.ch[0].done_irq;
    assign channel_two_completion_irq_o = st.ch[1].done_irq;

    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_out
        assign tc_o[c] = st.ch[c].tc;
        assign flush_o[c] = st.ch[c].flush;
        assign busy_o[c] = st.ch[c].busy;
        assign link_style_select_o[c] = st.ch[c].cfg[LINK_STYLE_BIT];
        assign descriptor_start_pointer_o[c] = st.ch[c].desc_ptr;
        assign src_addr_o[c] = st.ch[c].src;
        assign dst_addr_o[c] = st.ch[c].dst;
    end

endmodule
